//--- ring_redundancy_node.sv
// ring redundancy node: roles, ring port states, probing, voting, ahb-lite registers
`timescale 1ns/1ps
module ring_redundancy_node #(
	parameter int unsigned NPORTS = 6
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// ahb-lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// phy link pins
	input wire logic [NPORTS-1:0] link_up_in,
	// received frame classification
	input wire ring_node_pkg::rx_frame_s rx_frame_in,
	output logic rx_accept_out,
	// transmit request
	output ring_node_pkg::tx_frame_s tx_frame_out,
	output logic tx_valid_out,
	input wire logic tx_ready_in,
	// ring status
	output ring_node_pkg::port_state_e state_a_out,
	output ring_node_pkg::port_state_e state_b_out,
	output logic manager_out,
	output logic ring_open_out,
	output logic topo_flush_out
);
	typedef struct packed {
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic enable;
		logic [1:0] role_cfg;
		logic [1:0] profile;
		logic [2:0] port_a;
		logic [2:0] port_b;
		logic [15:0] prio;
		logic [47:0] mac;
		logic [15:0] interval;
		logic [7:0] miss_limit;
		logic [NPORTS-1:0] link_s1;
		logic [NPORTS-1:0] link_s2;
		logic [1:0] link_prev;
		logic manager;
		logic ring_open;
		ring_node_pkg::port_state_e state_a;
		ring_node_pkg::port_state_e state_b;
		logic [7:0] tick_cnt;
		logic [15:0] us_cnt;
		logic [7:0] miss_cnt;
		logic seen;
		logic [ring_node_pkg::PEND_W-1:0] pend;
		logic [47:0] reject_mac;
		logic link_down;
		logic tx_valid;
		ring_node_pkg::tx_frame_s tx;
		logic flush;
	} state_s;

	state_s st_reg;
	state_s st_next;
	logic ahb_go;
	logic ctrl_wr;
	logic cfg_err;
	logic run;
	logic la;
	logic lb;
	logic tick;
	logic period;
	logic rx_ring;
	logic own_probe;
	logic other_probe;
	logic own_better;
	logic rej_me;
	logic client_ok;
	logic [ring_node_pkg::MAX_PORTS-1:0] ring_mask;

	// register read mux; unmapped offsets read zero
	function automatic logic [31:0] read_reg(input state_s r, input logic [7:0] a, input logic err);
		logic [31:0] d;
		d = 32'h0;
		case (a)
			ring_node_pkg::OFS_CTRL: begin
				d[ring_node_pkg::CTRL_EN] = r.enable;
				d[ring_node_pkg::CTRL_ROLE +: 2] = r.role_cfg;
				d[ring_node_pkg::CTRL_PROF +: 2] = r.profile;
			end
			ring_node_pkg::OFS_PORTS: begin
				d[2:0] = r.port_a;
				d[ring_node_pkg::PORTS_B +: 3] = r.port_b;
			end
			ring_node_pkg::OFS_PRIO: d[15:0] = r.prio;
			ring_node_pkg::OFS_MAC_LO: d = r.mac[31:0];
			ring_node_pkg::OFS_MAC_HI: d[15:0] = r.mac[47:32];
			ring_node_pkg::OFS_TIMING: begin
				d[15:0] = r.interval;
				d[ring_node_pkg::TIM_MISS +: 8] = r.miss_limit;
			end
			ring_node_pkg::OFS_STATUS: begin
				d[ring_node_pkg::ST_MGR] = r.manager;
				d[ring_node_pkg::ST_OPEN] = r.ring_open;
				d[ring_node_pkg::ST_SA +: 2] = r.state_a;
				d[ring_node_pkg::ST_SB +: 2] = r.state_b;
				d[ring_node_pkg::ST_ERR] = err;
				d[ring_node_pkg::ST_LINK +: 2] = r.link_prev;
			end
			default: d = 32'h0;
		endcase
		return d;
	endfunction

	// decode of bus, configuration and frame events from registered state
	assign ahb_go = hsel_in && htrans_in[1] && hready_in;
	assign ctrl_wr = st_reg.wr_pend && (st_reg.wr_addr == ring_node_pkg::OFS_CTRL);
	assign cfg_err = (st_reg.port_a == st_reg.port_b) || (32'(st_reg.port_a) >= NPORTS) ||
		(32'(st_reg.port_b) >= NPORTS);
	assign run = st_reg.enable && !cfg_err && !ctrl_wr;
	assign la = (32'(st_reg.port_a) < NPORTS) ? st_reg.link_s2[st_reg.port_a] : 1'b0;
	assign lb = (32'(st_reg.port_b) < NPORTS) ? st_reg.link_s2[st_reg.port_b] : 1'b0;
	assign tick = (st_reg.tick_cnt == 8'(ring_node_pkg::TICK_CYCLES - 1));
	assign period = tick && ((st_reg.us_cnt + 16'h0001) >= st_reg.interval);
	assign ring_mask = (8'h01 << st_reg.port_a) | (8'h01 << st_reg.port_b);
	assign rx_ring = rx_accept_out && ((rx_frame_in.port == st_reg.port_a) ||
		(rx_frame_in.port == st_reg.port_b));
	assign own_probe = rx_ring && (rx_frame_in.kind == ring_node_pkg::FK_PROBE) &&
		(rx_frame_in.src_mac == st_reg.mac);
	assign other_probe = rx_ring && (rx_frame_in.kind == ring_node_pkg::FK_PROBE) &&
		(rx_frame_in.src_mac != st_reg.mac);
	assign own_better = {st_reg.prio, st_reg.mac} < {rx_frame_in.prio, rx_frame_in.src_mac};
	assign rej_me = rx_ring && (rx_frame_in.kind == ring_node_pkg::FK_REJECT) &&
		(rx_frame_in.named_mac == st_reg.mac);
	assign client_ok = !st_reg.manager && st_reg.enable && !cfg_err && la && lb;

	// ingress filter from the registered port states, so a frame never sees a half change
	always_comb begin
		rx_accept_out = rx_frame_in.valid;
		if (rx_frame_in.port == st_reg.port_a || rx_frame_in.port == st_reg.port_b) begin
			unique case ((rx_frame_in.port == st_reg.port_a) ? st_reg.state_a : st_reg.state_b)
				ring_node_pkg::PS_DISABLED: rx_accept_out = 1'b0;
				ring_node_pkg::PS_BLOCKING: rx_accept_out = rx_frame_in.valid &&
					(rx_frame_in.kind != ring_node_pkg::FK_OTHER);
				ring_node_pkg::PS_FORWARDING: rx_accept_out = rx_frame_in.valid;
			endcase
		end
	end

	// next state: bus, timers, role logic, port states and transmit queue
	always_comb begin
		st_next = st_reg;
		st_next.flush = 1'b0;
		st_next.link_s1 = link_up_in;
		st_next.link_s2 = st_reg.link_s1;
		st_next.link_prev = {lb, la};
		// data phase write
		if (st_reg.wr_pend) begin
			case (st_reg.wr_addr)
				ring_node_pkg::OFS_CTRL: begin
					st_next.enable = hwdata_in[ring_node_pkg::CTRL_EN];
					st_next.role_cfg = hwdata_in[ring_node_pkg::CTRL_ROLE +: 2];
					st_next.profile = hwdata_in[ring_node_pkg::CTRL_PROF +: 2];
					st_next.manager = (st_next.role_cfg == ring_node_pkg::ROLE_MANAGER) ||
						(st_next.role_cfg == ring_node_pkg::ROLE_AUTO);
					st_next.ring_open = 1'b0;
					st_next.miss_cnt = 8'h00;
					st_next.seen = 1'b0;
					st_next.pend = '0;
					// profile loads matching timing; a later timing write may refine it
					case (st_next.profile)
						ring_node_pkg::PROF_500: begin
							st_next.interval = ring_node_pkg::IVL_500;
							st_next.miss_limit = ring_node_pkg::MISS_500;
						end
						ring_node_pkg::PROF_30: begin
							st_next.interval = ring_node_pkg::IVL_30;
							st_next.miss_limit = ring_node_pkg::MISS_30;
						end
						default: begin
							st_next.interval = ring_node_pkg::IVL_200;
							st_next.miss_limit = ring_node_pkg::MISS_200;
						end
					endcase
				end
				ring_node_pkg::OFS_PORTS: begin
					st_next.port_a = hwdata_in[2:0];
					st_next.port_b = hwdata_in[ring_node_pkg::PORTS_B +: 3];
				end
				ring_node_pkg::OFS_PRIO: st_next.prio = hwdata_in[15:0];
				ring_node_pkg::OFS_MAC_LO: st_next.mac[31:0] = hwdata_in;
				ring_node_pkg::OFS_MAC_HI: st_next.mac[47:32] = hwdata_in[15:0];
				ring_node_pkg::OFS_TIMING: begin
					st_next.interval = hwdata_in[15:0];
					st_next.miss_limit = hwdata_in[ring_node_pkg::TIM_MISS +: 8];
				end
				default: st_next.wr_pend = 1'b0;
			endcase
		end
		// address phase; read data sees a write from the cycle before
		st_next.wr_pend = ahb_go && hwrite_in;
		st_next.wr_addr = {haddr_in[7:2], 2'b00};
		if (ahb_go && !hwrite_in) begin
			st_next.rdata = read_reg(st_next, {haddr_in[7:2], 2'b00}, cfg_err);
		end
		// microsecond tick and probe period
		st_next.tick_cnt = tick ? 8'h00 : st_reg.tick_cnt + 8'h01;
		if (period) begin
			st_next.us_cnt = 16'h0000;
		end else if (tick) begin
			st_next.us_cnt = st_reg.us_cnt + 16'h0001;
		end
		if (run && st_reg.manager) begin
			if (period) begin
				if (st_reg.seen) begin
					st_next.miss_cnt = 8'h00;
				end else if (st_reg.miss_cnt != 8'hFF) begin
					st_next.miss_cnt = st_reg.miss_cnt + 8'h01;
				end
				st_next.seen = 1'b0;
				st_next.pend[ring_node_pkg::P_PROBE] = 1'b1;
			end
			if (!st_reg.ring_open && st_reg.miss_cnt >= st_reg.miss_limit) begin
				st_next.ring_open = 1'b1;
				st_next.pend[ring_node_pkg::P_TOPO] = 1'b1;
			end
			if (rx_ring && rx_frame_in.kind == ring_node_pkg::FK_LINK && rx_frame_in.link_down) begin
				st_next.ring_open = 1'b1;
				st_next.pend[ring_node_pkg::P_TOPO] = 1'b1;
			end
			if (own_probe) begin
				st_next.seen = 1'b1;
				st_next.miss_cnt = 8'h00;
				if (st_reg.ring_open) begin
					st_next.ring_open = 1'b0;
					st_next.pend[ring_node_pkg::P_TOPO] = 1'b1;
				end
			end
			if (other_probe && own_better) begin
				st_next.reject_mac = rx_frame_in.src_mac;
				st_next.pend[ring_node_pkg::P_REJECT] = 1'b1;
			end
			// a fixed manager never yields; only an auto node steps down
			if (rej_me && st_reg.role_cfg == ring_node_pkg::ROLE_AUTO) begin
				st_next.manager = 1'b0;
				st_next.ring_open = 1'b0;
				st_next.miss_cnt = 8'h00;
				st_next.seen = 1'b0;
				st_next.pend[ring_node_pkg::P_PROBE] = 1'b0;
				st_next.pend[ring_node_pkg::P_ROLE] = 1'b1;
			end
		end else if (run) begin
			// client: watch the manager's probes when able to take over
			if (period && st_reg.role_cfg == ring_node_pkg::ROLE_AUTO) begin
				if (st_reg.seen) begin
					st_next.miss_cnt = 8'h00;
				end else if (st_reg.miss_cnt >= st_reg.miss_limit) begin
					st_next.manager = 1'b1;
					st_next.miss_cnt = 8'h00;
				end else begin
					st_next.miss_cnt = st_reg.miss_cnt + 8'h01;
				end
				st_next.seen = 1'b0;
			end
			if (own_probe || other_probe) begin
				st_next.seen = 1'b1;
			end
			if (rx_ring && rx_frame_in.kind == ring_node_pkg::FK_TOPOLOGY) begin
				st_next.flush = 1'b1;
			end
			if (la != st_reg.link_prev[0] || lb != st_reg.link_prev[1]) begin
				st_next.link_down = !(la && lb);
				st_next.pend[ring_node_pkg::P_LINK] = 1'b1;
			end
		end
		if (!st_reg.enable) begin
			st_next.pend = '0;
		end
		// both port states leave one register together
		if (!st_reg.enable || cfg_err) begin
			st_next.state_a = ring_node_pkg::PS_DISABLED;
			st_next.state_b = ring_node_pkg::PS_DISABLED;
		end else begin
			st_next.state_a = la ? ring_node_pkg::PS_FORWARDING : ring_node_pkg::PS_DISABLED;
			if (!lb) begin
				st_next.state_b = ring_node_pkg::PS_DISABLED;
			end else if (st_reg.manager && !st_reg.ring_open) begin
				st_next.state_b = ring_node_pkg::PS_BLOCKING;
			end else begin
				st_next.state_b = ring_node_pkg::PS_FORWARDING;
			end
		end
		// transmit slot: role change first, probes last; a freshly set slot is taken, not lost
		if (st_reg.tx_valid && tx_ready_in) begin
			st_next.tx_valid = 1'b0;
		end
		if (!st_reg.tx_valid || tx_ready_in) begin
			st_next.tx_valid = |st_next.pend;
			st_next.tx.port_mask = ring_mask;
			st_next.tx.prio = st_reg.prio;
			st_next.tx.src_mac = st_reg.mac;
			st_next.tx.named_mac = st_next.reject_mac;
			st_next.tx.link_down = st_next.link_down;
			if (st_next.pend[ring_node_pkg::P_ROLE]) begin
				st_next.tx.kind = ring_node_pkg::FK_ROLE;
				st_next.pend[ring_node_pkg::P_ROLE] = 1'b0;
			end else if (st_next.pend[ring_node_pkg::P_REJECT]) begin
				st_next.tx.kind = ring_node_pkg::FK_REJECT;
				st_next.pend[ring_node_pkg::P_REJECT] = 1'b0;
			end else if (st_next.pend[ring_node_pkg::P_TOPO]) begin
				st_next.tx.kind = ring_node_pkg::FK_TOPOLOGY;
				st_next.pend[ring_node_pkg::P_TOPO] = 1'b0;
			end else if (st_next.pend[ring_node_pkg::P_LINK]) begin
				st_next.tx.kind = ring_node_pkg::FK_LINK;
				st_next.pend[ring_node_pkg::P_LINK] = 1'b0;
			end else if (st_next.pend[ring_node_pkg::P_PROBE]) begin
				st_next.tx.kind = ring_node_pkg::FK_PROBE;
				st_next.pend[ring_node_pkg::P_PROBE] = 1'b0;
			end
		end
	end

	// state register with synchronous reset
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st_reg <= '0;
			st_reg.port_a <= ring_node_pkg::RST_PORT_A;
			st_reg.port_b <= ring_node_pkg::RST_PORT_B;
			st_reg.prio <= ring_node_pkg::RST_PRIO;
			st_reg.mac <= ring_node_pkg::RST_MAC;
			st_reg.profile <= ring_node_pkg::PROF_200;
			st_reg.interval <= ring_node_pkg::IVL_200;
			st_reg.miss_limit <= ring_node_pkg::MISS_200;
			st_reg.state_a <= ring_node_pkg::PS_DISABLED;
			st_reg.state_b <= ring_node_pkg::PS_DISABLED;
			st_reg.tx.kind <= ring_node_pkg::FK_OTHER;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs; zero-wait slave, always okay
	assign hrdata_out = st_reg.rdata;
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign tx_frame_out = st_reg.tx;
	assign tx_valid_out = st_reg.tx_valid;
	assign state_a_out = st_reg.state_a;
	assign state_b_out = st_reg.state_b;
	assign manager_out = st_reg.manager;
	assign ring_open_out = st_reg.ring_open;
	assign topo_flush_out = st_reg.flush;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	property p_mgr_blocks;
		st_reg.manager && !st_reg.ring_open && $past(st_reg.manager) && !$past(st_reg.ring_open)
			|-> st_reg.state_b != ring_node_pkg::PS_FORWARDING;
	endproperty
	a_mgr_blocks: assert property (p_mgr_blocks) else $error("closed ring manager forwards port b");

	property p_miss_opens;
		run && st_reg.manager && !st_reg.ring_open && st_reg.miss_cnt >= st_reg.miss_limit &&
			!own_probe && !rej_me |=> st_reg.ring_open;
	endproperty
	a_miss_opens: assert property (p_miss_opens) else $error("missed probes did not open ring");

	property p_open_notice;
		$rose(st_reg.ring_open) |-> st_reg.pend[ring_node_pkg::P_TOPO] ||
			(st_reg.tx_valid && st_reg.tx.kind == ring_node_pkg::FK_TOPOLOGY);
	endproperty
	a_open_notice: assert property (p_open_notice) else $error("ring opened without topology notice");

	property p_client_fwd;
		$past(client_ok) |-> st_reg.state_a == ring_node_pkg::PS_FORWARDING &&
			st_reg.state_b == ring_node_pkg::PS_FORWARDING;
	endproperty
	a_client_fwd: assert property (p_client_fwd) else $error("client ring port not forwarding");

	property p_link_notice;
		run && !st_reg.manager && (la != st_reg.link_prev[0]) |=> st_reg.pend[ring_node_pkg::P_LINK] ||
			(st_reg.tx_valid && st_reg.tx.kind == ring_node_pkg::FK_LINK);
	endproperty
	a_link_notice: assert property (p_link_notice) else $error("link change not reported");

	property p_err_disables;
		cfg_err ##1 cfg_err |-> st_reg.state_a == ring_node_pkg::PS_DISABLED &&
			st_reg.state_b == ring_node_pkg::PS_DISABLED;
	endproperty
	a_err_disables: assert property (p_err_disables) else $error("bad ring port pair left active");

	property p_disabled_drop;
		rx_frame_in.valid && rx_frame_in.port == st_reg.port_a &&
			st_reg.state_a == ring_node_pkg::PS_DISABLED |-> !rx_accept_out;
	endproperty
	a_disabled_drop: assert property (p_disabled_drop) else $error("disabled port accepted frame");

	property p_block_filter;
		rx_frame_in.valid && rx_frame_in.port == st_reg.port_b && st_reg.state_b ==
			ring_node_pkg::PS_BLOCKING |-> rx_accept_out == (rx_frame_in.kind != ring_node_pkg::FK_OTHER);
	endproperty
	a_block_filter: assert property (p_block_filter) else $error("blocking port filter wrong");

	property p_fwd_pass;
		rx_frame_in.valid && rx_frame_in.port == st_reg.port_a &&
			st_reg.state_a == ring_node_pkg::PS_FORWARDING |-> rx_accept_out;
	endproperty
	a_fwd_pass: assert property (p_fwd_pass) else $error("forwarding port dropped frame");

	property p_reject_demotes;
		run && st_reg.manager && rej_me && st_reg.role_cfg == ring_node_pkg::ROLE_AUTO |=>
			!st_reg.manager ##0 (st_reg.pend[ring_node_pkg::P_ROLE] ||
			(st_reg.tx_valid && st_reg.tx.kind == ring_node_pkg::FK_ROLE));
	endproperty
	a_reject_demotes: assert property (p_reject_demotes) else $error("reject did not demote node");
endmodule

//--- ring_node_pkg.sv
// package: constants, encodings and carriers for the ring redundancy node
package ring_node_pkg;
	// clock and microsecond tick
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned TICK_NS = 1000;
	localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PORTS = 8'h04;
	localparam logic [7:0] OFS_PRIO = 8'h08;
	localparam logic [7:0] OFS_MAC_LO = 8'h0C;
	localparam logic [7:0] OFS_MAC_HI = 8'h10;
	localparam logic [7:0] OFS_TIMING = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	// field positions
	localparam int unsigned CTRL_EN = 0;
	localparam int unsigned CTRL_ROLE = 1;
	localparam int unsigned CTRL_PROF = 4;
	localparam int unsigned PORTS_B = 4;
	localparam int unsigned TIM_MISS = 16;
	localparam int unsigned ST_MGR = 0;
	localparam int unsigned ST_OPEN = 1;
	localparam int unsigned ST_SA = 2;
	localparam int unsigned ST_SB = 4;
	localparam int unsigned ST_ERR = 6;
	localparam int unsigned ST_LINK = 7;
	// configured node roles; code 3 behaves as client
	localparam logic [1:0] ROLE_CLIENT = 2'h0;
	localparam logic [1:0] ROLE_MANAGER = 2'h1;
	localparam logic [1:0] ROLE_AUTO = 2'h2;
	// recovery profiles
	localparam logic [1:0] PROF_500 = 2'h0;
	localparam logic [1:0] PROF_200 = 2'h1;
	localparam logic [1:0] PROF_30 = 2'h2;
	// probe interval in microseconds and miss limit per profile
	localparam logic [15:0] IVL_500 = 16'h4E20;
	localparam logic [7:0] MISS_500 = 8'h05;
	localparam logic [15:0] IVL_200 = 16'h2710;
	localparam logic [7:0] MISS_200 = 8'h03;
	localparam logic [15:0] IVL_30 = 16'h03E8;
	localparam logic [7:0] MISS_30 = 8'h03;
	// reset values
	localparam logic [2:0] RST_PORT_A = 3'h1;
	localparam logic [2:0] RST_PORT_B = 3'h2;
	localparam logic [15:0] RST_PRIO = 16'h8000;
	localparam logic [47:0] RST_MAC = 48'h020000000001; // arbitrary value
	// pending transmit slots
	localparam int unsigned P_PROBE = 0;
	localparam int unsigned P_TOPO = 1;
	localparam int unsigned P_LINK = 2;
	localparam int unsigned P_REJECT = 3;
	localparam int unsigned P_ROLE = 4;
	localparam int unsigned PEND_W = 5;
	localparam int unsigned MAX_PORTS = 8;
	typedef enum logic [1:0] {PS_DISABLED, PS_BLOCKING, PS_FORWARDING} port_state_e;
	typedef enum logic [2:0] {FK_OTHER, FK_PROBE, FK_TOPOLOGY, FK_LINK, FK_REJECT, FK_ROLE, FK_PTP,
		FK_LLDP} frame_kind_e;
	typedef struct packed {
		logic valid;
		logic [2:0] port;
		frame_kind_e kind;
		logic [15:0] prio;
		logic [47:0] src_mac;
		logic [47:0] named_mac;
		logic link_down;
	} rx_frame_s;
	typedef struct packed {
		frame_kind_e kind;
		logic [MAX_PORTS-1:0] port_mask;
		logic [15:0] prio;
		logic [47:0] src_mac;
		logic [47:0] named_mac;
		logic link_down;
	} tx_frame_s;
endpackage

//--- ring_neighbor.sv
// partner model: neighbouring ring node that takes transmit requests and echoes probes
`timescale 1ns/1ps
module ring_neighbor (
	// clock
	input wire logic clk_in,
	// node transmit side
	input wire ring_node_pkg::tx_frame_s tx_frame_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	// scenario controls
	input wire logic stall_in,
	input wire logic loop_in,
	input wire logic clr_in,
	// observations and echoed frame
	output logic [7:0] seen_out,
	output logic [47:0] named_out,
	output ring_node_pkg::rx_frame_s rx_frame_out
);
	// a stall stands for a slow neighbour
	assign tx_ready_out = !stall_in;
	// record taken frames and send probes back round the closed ring
	always_ff @(posedge clk_in) begin
		rx_frame_out.valid <= 1'b0;
		rx_frame_out.prio <= ~rx_frame_out.prio; // idle line must not keep its last value
		if (clr_in) begin
			seen_out <= 8'h00;
			rx_frame_out <= '0; // start the line from a known idle frame
		end
		if (tx_valid_in && !stall_in) begin
			seen_out[tx_frame_in.kind] <= 1'b1;
			if (tx_frame_in.kind == ring_node_pkg::FK_REJECT) begin
				named_out <= tx_frame_in.named_mac;
			end
			if (loop_in && tx_frame_in.kind == ring_node_pkg::FK_PROBE) begin
				rx_frame_out <= '{1'b1, 3'h2, ring_node_pkg::FK_PROBE, tx_frame_in.prio, tx_frame_in.src_mac, 48'h0, 1'b0};
			end
		end
	end
endmodule

//--- tb_top.sv
// testbench: drives the ring node over the bus and frame ports against a neighbour model
`timescale 1ns/1ps
module tb_top;
	logic clk_in, sys_rst_in, hsel, hwrite, hready, acc, acc_w, fl, stall, loopb, clr, txv, txr, mgr, ropen, flush;
	logic hresp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [5:0] link;
	logic [7:0] seen;
	logic [47:0] named;
	ring_node_pkg::rx_frame_s inj, echo, rxf;
	ring_node_pkg::tx_frame_s txf;
	ring_node_pkg::port_state_e sa, sb;
	int num_errors = 0;
	int samples_checked = 0;
	// injected frames take the line over the echo
	assign rxf = inj.valid ? inj : echo;
	ring_redundancy_node u_ring_redundancy_node (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .link_up_in(link),
		.rx_frame_in(rxf), .rx_accept_out(acc_w), .tx_frame_out(txf), .tx_valid_out(txv), .tx_ready_in(txr),
		.state_a_out(sa), .state_b_out(sb), .manager_out(mgr), .ring_open_out(ropen), .topo_flush_out(flush));
	ring_neighbor u_ring_neighbor (.clk_in(clk_in), .tx_frame_in(txf), .tx_valid_in(txv), .tx_ready_out(txr),
		.stall_in(stall), .loop_in(loopb), .clr_in(clr), .seen_out(seen), .named_out(named), .rx_frame_out(echo));
	// 20 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	task give_verdict;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [47:0] s, input logic [47:0] e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	function automatic logic cond(input int c);
		case (c)
			0: return ropen === 1'b1;
			1: return mgr === 1'b0;
			8: return mgr === 1'b1;
			9: return hready === 1'b1;
			default: return seen[c-2] === 1'b1;
		endcase
	endfunction
	// bounded wait, sampled at rising edges; running out is a mismatch
	task wait_ok(input int c);
		int n;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (!cond(c) && n < 3000);
		if (!cond(c)) begin
			chk(48'h0, 48'h1);
			give_verdict;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_ok(9);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ok(9);
		rd = hrdata;
		// a write lands at the last edge; callers look only after it has settled
		@(posedge clk_in);
	endtask
	// one frame for one cycle; accept seen in that cycle, flush just after
	task send(input logic [2:0] p, input ring_node_pkg::frame_kind_e k, input logic [15:0] pr, input logic [47:0] nm);
		@(posedge clk_in);
		inj <= '{1'b1, p, k, pr, 48'h0A, nm, 1'b0};
		#1 acc = acc_w;
		@(posedge clk_in);
		inj.valid <= 1'b0;
		#1 fl = flush;
	endtask
	task clear_seen;
		clr <= 1'b1;
		@(posedge clk_in);
		clr <= 1'b0;
	endtask
	task t_reset;
		bus(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h21);
		bus(1'b1, 8'h18, 32'hFFFFFFFF);
		bus(1'b0, 8'h18, 32'h0);
		chk(rd, 32'h180);
		bus(1'b0, 8'h1C, 32'h0);
		chk(rd, 32'h0);
		send(3'h1, ring_node_pkg::FK_PROBE, 16'h1, 48'h0);
		chk(acc, 1'b0);
	endtask
	task t_manager;
		bus(1'b1, 8'h00, 32'h3);
		bus(1'b1, 8'h14, 32'h00020005);
		chk(mgr, 1'b1);
		chk(sb, ring_node_pkg::PS_BLOCKING);
		chk(sa, ring_node_pkg::PS_FORWARDING);
		send(3'h2, ring_node_pkg::FK_OTHER, 16'h1, 48'h0);
		chk(acc, 1'b0);
		send(3'h2, ring_node_pkg::FK_PTP, 16'h1, 48'h0);
		chk(acc, 1'b1);
		send(3'h2, ring_node_pkg::FK_LLDP, 16'h1, 48'h0);
		chk(acc, 1'b1);
		send(3'h1, ring_node_pkg::FK_OTHER, 16'h1, 48'h0);
		chk(acc, 1'b1);
		stall <= 1'b1;
		repeat (130) @(posedge clk_in);
		chk(txv, 1'b1);
		chk(txf.port_mask, 8'h06);
		stall <= 1'b0;
		repeat (400) @(posedge clk_in);
		chk(ropen, 1'b0);
		clear_seen;
		loopb <= 1'b0;
		wait_ok(0);
		// port state follows the open flag one edge later
		repeat (2) @(posedge clk_in);
		chk(sb, ring_node_pkg::PS_FORWARDING);
		wait_ok(4);
		chk(seen[ring_node_pkg::FK_TOPOLOGY], 1'b1);
	endtask
	task t_client;
		bus(1'b1, 8'h00, 32'h1);
		chk(mgr, 1'b0);
		@(posedge clk_in);
		chk({sa, sb}, {ring_node_pkg::PS_FORWARDING, ring_node_pkg::PS_FORWARDING});
		send(3'h1, ring_node_pkg::FK_TOPOLOGY, 16'h1, 48'h0);
		chk(fl, 1'b1);
		clear_seen;
		link <= 6'h3D;
		wait_ok(5);
		chk(seen[ring_node_pkg::FK_LINK], 1'b1);
		chk(txf.link_down, 1'b1);
		link <= 6'h3F;
	endtask
	task t_auto;
		bus(1'b1, 8'h00, 32'h5);
		chk(mgr, 1'b1);
		clear_seen;
		send(3'h1, ring_node_pkg::FK_PROBE, 16'hFFFF, 48'h0);
		wait_ok(6);
		chk(named, 48'h0A);
		chk(txf.prio, ring_node_pkg::RST_PRIO);
		send(3'h1, ring_node_pkg::FK_REJECT, 16'h1, ring_node_pkg::RST_MAC);
		wait_ok(1);
		wait_ok(7);
		chk(seen[ring_node_pkg::FK_ROLE], 1'b1);
		// no probes return, so the demoted auto node must take over again
		bus(1'b1, 8'h14, 32'h00020002);
		wait_ok(8);
		chk(mgr, 1'b1);
	endtask
	task t_cfgerr;
		bus(1'b1, 8'h04, 32'h11);
		chk(hresp, 1'b0);
		@(posedge clk_in);
		chk(sa, ring_node_pkg::PS_DISABLED);
		send(3'h1, ring_node_pkg::FK_OTHER, 16'h1, 48'h0);
		chk(acc, 1'b0);
	endtask
	// main sequence
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, stall} = '0;
		{link, loopb, clr, sys_rst_in} = {6'h3F, 3'h7};
		inj = '0;
		repeat (8) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		clr <= 1'b0;
		t_reset;
		t_manager;
		t_client;
		t_auto;
		t_cfgerr;
		give_verdict;
	end
endmodule
